// *** include/dso_pkg.sv ***
// Constants, types and helpers for the drive status-output block.
// Assumes one 25 MHz clock and an AHB-Lite master with word accesses only.
//
// Contract
// RL1 - Overload warning A follows current above threshold
// RL2 - Overload warning B, own independent threshold
// RL3 - Overload compared while powering and regenerating
// RL4 - Both overload thresholds reset to 100%
// RL5 - Open-collector outputs are active low
// RL6 - Deviation warning when absolute PID error exceeds level
// RL7 - Deviation level resets to 3%
// RL8 - Alarm holds through trip, clears with it
// RL9 - Alarm routable anywhere; relay carries it by default
// RL10 - Normally-closed relay energizes after power-up, drops on trip
// RL11 - Normally-open relay energizes only on trip
// RL12 - Alarm follows the fault by 300 ms
// RL13 - Overtorque warning while torque exceeds its level
// RL14 - Overtorque only meaningful in sensorless vector mode
// RL15 - Lift controller stops braking on overtorque
// RL16 - Comparisons refresh once per control update
package dso_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ALARM_DELAY_MS = 300;
  localparam int unsigned POWERUP_MAX_MS = 2000;
  localparam int unsigned ALARM_DELAY_CYCLES = ALARM_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned POWERUP_CYCLES = POWERUP_MAX_MS * (CLK_HZ / 1000);

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OL_A = 8'h04;
  localparam logic [7:0] REG_OL_B = 8'h08;
  localparam logic [7:0] REG_DEV = 8'h0c;
  localparam logic [7:0] REG_OTQ = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_INT_STATUS = 8'h18;
  localparam logic [7:0] REG_INT_MASK = 8'h1c;

  // ****************************************
  // Option codes (decimal codes held in binary)
  // ****************************************
  localparam logic [7:0] OPT_OVERLOAD_A = 8'h03;
  localparam logic [7:0] OPT_DEVIATION = 8'h04;
  localparam logic [7:0] OPT_ALARM = 8'h05;
  localparam logic [7:0] OPT_OVERTORQUE = 8'h07;
  localparam logic [7:0] OPT_OVERLOAD_B = 8'h1a;
  localparam logic [3:0] METHOD_SENSORLESS_VECTOR = 4'h3;

  // ****************************************
  // Reset values (levels in 0.1 % of rated, torque in %)
  // ****************************************
  localparam logic [15:0] RST_OL_LEVEL = 16'h03e8;
  localparam logic [15:0] RST_DEV_LEVEL = 16'h001e;
  localparam logic [31:0] RST_OTQ_LEVELS = 32'h64646464;
  localparam logic [7:0] RST_OC0_FUNC = OPT_OVERLOAD_A;
  localparam logic [7:0] RST_OC1_FUNC = OPT_DEVIATION;
  localparam logic [7:0] RST_RELAY_FUNC = OPT_ALARM;
  localparam logic RST_RELAY_NC = 1'b1;
  localparam logic [3:0] RST_METHOD = 4'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_OC1_LSB = 8;
  localparam int unsigned CTRL_RELAY_LSB = 16;
  localparam int unsigned CTRL_NC_BIT = 24;
  localparam int unsigned CTRL_METHOD_LSB = 28;
  localparam int unsigned EV_OL_A = 0;
  localparam int unsigned EV_OL_B = 1;
  localparam int unsigned EV_DEV = 2;
  localparam int unsigned EV_ALARM = 3;
  localparam int unsigned EV_OTQ = 4;
  localparam int unsigned EV_COUNT = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] setpoint;
    logic [15:0] process;
    logic [7:0] torque;
    logic [1:0] quadrant;
  } dso_meas_type;

  typedef struct packed {
    logic [7:0] oc0_func;
    logic [7:0] oc1_func;
    logic [7:0] relay_func;
    logic relay_nc;
    logic [3:0] method;
  } dso_ctrl_type;

  function automatic logic [15:0] dso_abs_diff(input logic [15:0] a, input logic [15:0] b);
    dso_abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// *** hdl/dso_cmp.sv ***
// Threshold comparator refreshed on each control update strobe.
// Assumes value and level are unsigned and stable at the strobe.
`timescale 1ns/1ps
module dso_cmp #(parameter int unsigned WIDTH = 16)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Compare
  input wire logic update,
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] level,
  output logic above
);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      above <= 1'b0;
    else if (update)
      above <= value > level; // [RL16]
  end

endmodule // dso_cmp

// *** hdl/dso_delay.sv ***
// On-delay: done rises after level_in has been high for COUNT edges.
// Drops one edge after level_in falls.
`timescale 1ns/1ps
module dso_delay #(parameter int unsigned COUNT = 16)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Delay
  input wire logic level_in,
  output logic done
);

  localparam int unsigned WIDTH = $clog2(COUNT + 1);
  logic [WIDTH-1:0] count;
  wire at_end = (count == WIDTH'(COUNT - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else if (!level_in)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else if (!done)
    begin
      if (at_end)
        done <= 1'b1;
      else
        count <= count + WIDTH'(1);
    end
  end

endmodule // dso_delay

// *** hdl/dso_top.sv ***
// Drive status outputs: overload, deviation, alarm, overtorque and relay.
// Assumes an AHB-Lite master, a control update strobe and synchronous inputs.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module dso_top #(
  parameter int unsigned ALARM_DELAY = dso_pkg::ALARM_DELAY_CYCLES,
  parameter int unsigned POWERUP_DELAY = dso_pkg::POWERUP_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Drive measurements
  input wire logic ctrl_update,
  input wire dso_pkg::dso_meas_type meas,
  input wire logic trip_state,
  // Terminals
  output logic [1:0] oc_out_n,
  output logic relay_coil,
  // Interrupt
  output logic irq
);
  import dso_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  dso_ctrl_type ctrl;
  logic [15:0] ol_a_level;
  logic [15:0] ol_b_level;
  logic [15:0] dev_level;
  logic [31:0] otq_levels;
  logic [EV_COUNT-1:0] int_status;
  logic [EV_COUNT-1:0] int_mask;
  logic [EV_COUNT-1:0] fn_prev;

  // ****************************************
  // Bus address phase
  // ****************************************
  logic ap_write;
  logic [7:0] ap_addr;
  wire ap_take = hsel & htrans[1] & hready;
  wire wr_en = ap_write;
  wire wr_ctrl = wr_en && (ap_addr == REG_CTRL);
  wire wr_ol_a = wr_en && (ap_addr == REG_OL_A);
  wire wr_ol_b = wr_en && (ap_addr == REG_OL_B);
  wire wr_dev = wr_en && (ap_addr == REG_DEV);
  wire wr_otq = wr_en && (ap_addr == REG_OTQ);
  wire wr_istat = wr_en && (ap_addr == REG_INT_STATUS);
  wire wr_imask = wr_en && (ap_addr == REG_INT_MASK);

  // ****************************************
  // Functions
  // ****************************************
  logic ol_a;
  logic ol_b;
  logic dev;
  logic otq_raw;
  logic trip_alarm;
  logic powered_up;
  wire [15:0] pid_error = dso_abs_diff(meas.setpoint, meas.process); // [RL6]
  wire [7:0] otq_level = otq_levels[8 * meas.quadrant +: 8];
  wire slv_mode = (ctrl.method == METHOD_SENSORLESS_VECTOR);
  wire overtorque_warn = otq_raw & slv_mode; // [RL14]
  wire [EV_COUNT-1:0] fn_vec = {overtorque_warn, trip_alarm, dev, ol_b, ol_a};

  // Regen state (meas.quadrant) only picks the overtorque level: overload detection never depends on it
  dso_cmp #(.WIDTH(16)) u_ol_a (
    .hclk(hclk), .hresetn(hresetn), .update(ctrl_update),
    .value(meas.current), .level(ol_a_level), .above(ol_a)); // [RL1] [RL3]
  dso_cmp #(.WIDTH(16)) u_ol_b (
    .hclk(hclk), .hresetn(hresetn), .update(ctrl_update),
    .value(meas.current), .level(ol_b_level), .above(ol_b)); // [RL2] [RL3]
  dso_cmp #(.WIDTH(16)) u_dev (
    .hclk(hclk), .hresetn(hresetn), .update(ctrl_update),
    .value(pid_error), .level(dev_level), .above(dev)); // [RL6]
  dso_cmp #(.WIDTH(8)) u_otq (
    .hclk(hclk), .hresetn(hresetn), .update(ctrl_update),
    .value(meas.torque), .level(otq_level), .above(otq_raw)); // [RL13]
  dso_delay #(.COUNT(ALARM_DELAY)) u_alarm (
    .hclk(hclk), .hresetn(hresetn), .level_in(trip_state), .done(trip_alarm)); // [RL8] [RL12]
  dso_delay #(.COUNT(POWERUP_DELAY)) u_powerup (
    .hclk(hclk), .hresetn(hresetn), .level_in(1'b1), .done(powered_up)); // [RL10]

  // Unknown option codes leave the terminal inactive
  function automatic logic fn_select(input logic [7:0] code, input logic [EV_COUNT-1:0] fv);
    if (code == OPT_OVERLOAD_A)
      fn_select = fv[EV_OL_A];
    else if (code == OPT_OVERLOAD_B)
      fn_select = fv[EV_OL_B];
    else if (code == OPT_DEVIATION)
      fn_select = fv[EV_DEV];
    else if (code == OPT_ALARM)
      fn_select = fv[EV_ALARM];
    else if (code == OPT_OVERTORQUE)
      fn_select = fv[EV_OTQ];
    else
      fn_select = 1'b0;
  endfunction

  wire sel_oc0 = fn_select(ctrl.oc0_func, fn_vec); // [RL9]
  wire sel_oc1 = fn_select(ctrl.oc1_func, fn_vec); // [RL9]
  wire relay_fn = fn_select(ctrl.relay_func, fn_vec); // [RL9]
  wire next_relay_coil = ctrl.relay_nc ? (powered_up & ~relay_fn) : relay_fn; // [RL10] [RL11]
  wire [EV_COUNT-1:0] ev_rise = fn_vec & ~fn_prev;
  wire [EV_COUNT-1:0] ev_clear = wr_istat ? hwdata[EV_COUNT-1:0] : '0;
  // Set wins over a simultaneous write-one-to-clear
  wire [EV_COUNT-1:0] next_int_status = (int_status & ~ev_clear) | ev_rise;

  // ****************************************
  // Read decode
  // ****************************************
  wire [31:0] rd_ctrl = {ctrl.method, 3'h0, ctrl.relay_nc, ctrl.relay_func, ctrl.oc1_func, ctrl.oc0_func};
  wire [31:0] rd_status = {25'h0, trip_state, relay_coil, fn_vec};
  logic [31:0] rd_mux;
  always_comb
  begin
    if (haddr[7:0] == REG_CTRL)
      rd_mux = rd_ctrl;
    else if (haddr[7:0] == REG_OL_A)
      rd_mux = {16'h0, ol_a_level};
    else if (haddr[7:0] == REG_OL_B)
      rd_mux = {16'h0, ol_b_level};
    else if (haddr[7:0] == REG_DEV)
      rd_mux = {16'h0, dev_level};
    else if (haddr[7:0] == REG_OTQ)
      rd_mux = otq_levels;
    else if (haddr[7:0] == REG_STATUS)
      rd_mux = rd_status;
    else if (haddr[7:0] == REG_INT_STATUS)
      rd_mux = {27'h0, int_status};
    else if (haddr[7:0] == REG_INT_MASK)
      rd_mux = {27'h0, int_mask};
    else
      rd_mux = 32'h0;
  end
  wire addr_in_map = (haddr[31:8] == 24'h0);

  // ****************************************
  // Bus slave
  // ****************************************
  // Read data is sampled at the address phase; zero wait states throughout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_write <= 1'b0;
      ap_addr <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      ap_write <= ap_take & hwrite & addr_in_map;
      ap_addr <= haddr[7:0];
      hrdata <= (ap_take & ~hwrite & addr_in_map) ? rd_mux : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= '{RST_OC0_FUNC, RST_OC1_FUNC, RST_RELAY_FUNC, RST_RELAY_NC, RST_METHOD}; // [RL9]
      ol_a_level <= RST_OL_LEVEL; // [RL4]
      ol_b_level <= RST_OL_LEVEL; // [RL4]
      dev_level <= RST_DEV_LEVEL; // [RL7]
      otq_levels <= RST_OTQ_LEVELS;
      int_mask <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= '{hwdata[7:0], hwdata[CTRL_OC1_LSB +: 8], hwdata[CTRL_RELAY_LSB +: 8],
                  hwdata[CTRL_NC_BIT], hwdata[CTRL_METHOD_LSB +: 4]};
      if (wr_ol_a)
        ol_a_level <= hwdata[15:0];
      if (wr_ol_b)
        ol_b_level <= hwdata[15:0];
      if (wr_dev)
        dev_level <= hwdata[15:0];
      if (wr_otq)
        otq_levels <= hwdata;
      if (wr_imask)
        int_mask <= hwdata[EV_COUNT-1:0];
    end
  end

  // ****************************************
  // Terminals and interrupt
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oc_out_n <= 2'b11;
      relay_coil <= 1'b0;
      int_status <= '0;
      fn_prev <= '0;
      irq <= 1'b0;
    end
    else
    begin
      oc_out_n <= {~sel_oc1, ~sel_oc0}; // [RL5]
      relay_coil <= next_relay_coil; // [RL10] [RL11]
      int_status <= next_int_status;
      fn_prev <= fn_vec;
      irq <= |(next_int_status & int_mask);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Helper: edges the trip input has been held high
  logic [31:0] trip_hold;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trip_hold <= 32'h0;
    else
      trip_hold <= trip_state ? trip_hold + 32'h1 : 32'h0;
  end

  sequence s_trip_gone;
    !trip_state;
  endsequence

  sequence s_alarm_down;
    ##1 !trip_alarm;
  endsequence

  property p_ol_a_cmp;
    ctrl_update |=> (ol_a == ($past(meas.current) > $past(ol_a_level)));
  endproperty
  a_ol_a_cmp: assert property (p_ol_a_cmp) else $error("overload A mismatch"); // [RL1]

  property p_ol_b_cmp;
    ctrl_update |=> (ol_b == ($past(meas.current) > $past(ol_b_level)));
  endproperty
  a_ol_b_cmp: assert property (p_ol_b_cmp) else $error("overload B mismatch"); // [RL2]

  property p_dev_cmp;
    ctrl_update |=> (dev == ($past(pid_error) > $past(dev_level)));
  endproperty
  a_dev_cmp: assert property (p_dev_cmp) else $error("deviation mismatch"); // [RL6]

  property p_hold_between;
    !ctrl_update |=> $stable(ol_a) && $stable(dev) && $stable(otq_raw);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("compare moved without update"); // [RL16]

  property p_oc_low;
    ##1 oc_out_n == {~$past(sel_oc1), ~$past(sel_oc0)};
  endproperty
  a_oc_low: assert property (p_oc_low) else $error("open collector polarity wrong"); // [RL5]

  property p_alarm_time;
    $rose(trip_alarm) |-> (trip_hold == ALARM_DELAY);
  endproperty
  a_alarm_time: assert property (p_alarm_time) else $error("alarm delay wrong"); // [RL12]

  property p_alarm_clear;
    s_trip_gone |-> s_alarm_down;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm outlived trip"); // [RL8]

  property p_relay_no;
    !ctrl.relay_nc |=> (relay_coil == $past(relay_fn));
  endproperty
  a_relay_no: assert property (p_relay_no) else $error("normally-open relay wrong"); // [RL11]

  property p_relay_nc;
    ctrl.relay_nc |=> (relay_coil == ($past(powered_up) && !$past(relay_fn)));
  endproperty
  a_relay_nc: assert property (p_relay_nc) else $error("normally-closed relay wrong"); // [RL10]

  property p_otq_mode;
    (!slv_mode && (ctrl.oc1_func == OPT_OVERTORQUE)) |=> oc_out_n[1];
  endproperty
  a_otq_mode: assert property (p_otq_mode) else $error("overtorque outside vector mode"); // [RL14]

endmodule // dso_top

// *** testbench/dso_ext_circuit.sv ***
// External control circuit on the status terminals and the relay.
// Assumes it only watches the block's registered terminal outputs.
`timescale 1ns/1ps
module dso_ext_circuit #(parameter int unsigned OTQ_TERM = 1)
(
  // Terminals from the block
  input wire logic [1:0] oc_out_n,
  input wire logic relay_coil,
  // Circuit state
  output logic [1:0] oc_on,
  output logic nc_closed,
  output logic no_closed,
  output logic stop_brake
);
  // ****************************************
  // Loads and contacts
  // ****************************************
  // Transistor conducts while its terminal is low
  assign oc_on = ~oc_out_n;
  // Energized coil opens the closed-at-rest path
  assign nc_closed = ~relay_coil;
  assign no_closed = relay_coil;
  // Lift controller stops braking on overtorque
  assign stop_brake = oc_on[OTQ_TERM];
endmodule // dso_ext_circuit

// *** testbench/test_dso_top.sv ***
// Self-checking bench for the drive status-output block.
// Assumes short delay parameters; the bus answers when hreadyout is high.
`timescale 1ns/1ps
module test_dso_top;
  import dso_pkg::*;
  typedef struct {logic [31:0] ctrl; logic [15:0] olb, cur, sp, pv; logic [7:0] tq; logic [1:0] qd, exp;} dso_row_type;
  localparam int unsigned ALARM_DELAY = 8;
  localparam int unsigned POWERUP_DELAY = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ctrl_update, trip_state, relay_coil, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, oc_out_n, oc_on;
  logic [2:0] hsize;
  logic nc_closed, no_closed, stop_brake;
  dso_meas_type meas;
  int n_mismatch, compares, cyc;
  // ****************************************
  // Tables
  // ****************************************
  logic [7:0] def_addr[7] = '{REG_CTRL, REG_OL_A, REG_OL_B, REG_DEV, REG_OTQ, REG_INT_MASK, 8'h40};
  logic [31:0] def_val[7] = '{32'h01050403, 32'h000003e8, 32'h000003e8, 32'h0000001e, RST_OTQ_LEVELS,
    32'h00000000, 32'h00000000};
  // Equal values sit in rows on purpose: equal is not above
  dso_row_type rows[7] = '{
    '{32'h31051a03, 16'h03e8, 16'h03e9, 16'h0000, 16'h0000, 8'h00, 2'h0, 2'b00},
    '{32'h31051a03, 16'h03e8, 16'h03e8, 16'h0000, 16'h0000, 8'h00, 2'h0, 2'b11},
    '{32'h31051a03, 16'h0100, 16'h0200, 16'h0000, 16'h0000, 8'h00, 2'h2, 2'b01},
    '{32'h31050704, 16'h03e8, 16'h0000, 16'h0064, 16'h0083, 8'h65, 2'h0, 2'b00},
    '{32'h31050704, 16'h03e8, 16'h0000, 16'h0083, 16'h0064, 8'h64, 2'h3, 2'b10},
    '{32'h31050704, 16'h03e8, 16'h0000, 16'h0064, 16'h0082, 8'h65, 2'h1, 2'b01},
    '{32'h01050704, 16'h03e8, 16'h0000, 16'h0064, 16'h0083, 8'hff, 2'h0, 2'b10}};
  assign hready = hreadyout;
  // ****************************************
  // Design and far side
  // ****************************************
  dso_top #(.ALARM_DELAY(ALARM_DELAY), .POWERUP_DELAY(POWERUP_DELAY)) u_dso_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ctrl_update(ctrl_update), .meas(meas), .trip_state(trip_state),
    .oc_out_n(oc_out_n), .relay_coil(relay_coil), .irq(irq));
  dso_ext_circuit u_dso_ext_circuit (.oc_out_n(oc_out_n), .relay_coil(relay_coil), .oc_on(oc_on),
    .nc_closed(nc_closed), .no_closed(no_closed), .stop_brake(stop_brake));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Terminal vector: oc_out_n, relay_coil, irq, open-at-rest path
  task automatic chk_pin(input logic [4:0] exp);
    compares++;
    if ({oc_out_n, relay_coil, irq, no_closed} !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {oc_out_n, relay_coil, irq, no_closed}, exp);
    end
  endtask
  // Single word transfer, held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_reg({31'h0, hresp}, 32'h0);
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Strobe one cycle, then give the two-edge answer time to land
  task automatic upd;
    @(posedge hclk);
    ctrl_update <= 1'b1;
    @(posedge hclk);
    ctrl_update <= 1'b0;
    edges(3);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    forever
    begin
      @(posedge hclk);
      cyc++;
      if (cyc >= 4000)
      begin
        n_mismatch++;
        tally_and_finish;
      end
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    ctrl_update = 1'b0;
    trip_state = 1'b0;
    meas = '0;
    edges(19);
    chk_pin(5'b11000);
    @(posedge hclk);
    hresetn <= 1'b1;
    edges(POWERUP_DELAY + 4);
    chk_pin(5'b11101);
    bus(1'b1, 8'h40, 32'hffffffff);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, def_addr[i], 32'h0);
      chk_reg(rd, def_val[i]);
    end
    $display("test reset_defaults done");
    foreach (rows[i])
    begin
      bus(1'b1, REG_CTRL, rows[i].ctrl);
      bus(1'b1, REG_OL_B, {16'h0, rows[i].olb});
      @(posedge hclk);
      meas <= '{current: rows[i].cur, setpoint: rows[i].sp, process: rows[i].pv, torque: rows[i].tq,
        quadrant: rows[i].qd};
      upd;
      chk_pin({rows[i].exp, 3'b101});
      chk_reg({30'h0, stop_brake, nc_closed}, {30'h0, ~rows[i].exp[1], 1'b0});
    end
    $display("test threshold_rows done");
    bus(1'b1, REG_CTRL, 32'h01050500);
    bus(1'b1, REG_INT_STATUS, 32'h0000001f);
    bus(1'b1, REG_INT_MASK, 32'h00000008);
    @(posedge hclk);
    trip_state <= 1'b1;
    edges(6);
    chk_pin(5'b11101);
    edges(6);
    chk_pin(5'b01010);
    bus(1'b0, REG_STATUS, 32'h0);
    chk_reg({28'h0, rd[6:3]}, 32'h00000009);
    bus(1'b0, REG_INT_STATUS, 32'h0);
    chk_reg(rd, 32'h00000008);
    @(posedge hclk);
    trip_state <= 1'b0;
    edges(3);
    chk_pin(5'b11111);
    bus(1'b1, REG_INT_STATUS, 32'h00000008);
    edges(2);
    chk_pin(5'b11101);
    $display("test alarm_closed_relay done");
    bus(1'b1, REG_INT_MASK, 32'h0);
    bus(1'b1, REG_CTRL, 32'h00050500);
    edges(3);
    chk_pin(5'b11000);
    @(posedge hclk);
    trip_state <= 1'b1;
    edges(12);
    chk_pin(5'b01101);
    bus(1'b0, REG_INT_STATUS, 32'h0);
    chk_reg(rd, 32'h00000008);
    trip_state <= 1'b0;
    $display("test alarm_open_relay done");
    hresetn <= 1'b0;
    edges(2);
    chk_pin(5'b11000);
    @(posedge hclk);
    hresetn <= 1'b1;
    edges(2);
    chk_pin(5'b11000);
    bus(1'b0, REG_CTRL, 32'h0);
    chk_reg(rd, 32'h01050403);
    edges(POWERUP_DELAY);
    chk_pin(5'b11101);
    $display("test mid_run_reset done");
    tally_and_finish;
  end
endmodule // test_dso_top
